// file: hw/conv_regs_defs.vh
// Constants for the converter status and calibration register block
`ifndef CONV_REGS_DEFS_VH
`define CONV_REGS_DEFS_VH

// Register port addresses
`define ADDR_CONTROL      4'h0
`define ADDR_DATA         4'h1
`define ADDR_STATUS       4'h2
`define ADDR_BUSY_CTRL    4'h3

// Control word fields
`define CTL_SGL_BIT       13
`define CTL_CH_HI         12
`define CTL_CH_LO         10
`define CTL_PWR_HI        9
`define CTL_PWR_LO        8
`define CTL_RD_HI         7
`define CTL_RD_LO         6
`define CTL_MODE_BIT      5
`define CTL_CONV_BIT      4
`define CTL_KIND_BIT      3
`define CTL_GRP_HI        2
`define CTL_GRP_LO        1
`define CTL_START_BIT     0

// Read targets
`define RD_STATUS         2'h3
`define RD_CAL            2'h2

// Calibration groups
`define GRP_ALL           2'h0
`define GRP_GAIN_OFS      2'h1
`define GRP_OFS           2'h2
`define GRP_GAIN          2'h3

// Pointer slots
`define PTR_GAIN          4'h0
`define PTR_OFS           4'h1
`define PTR_DAC_LAST      4'h9
`define CAL_COUNT         10

// Reset values
`define STATUS_RESET      16'h0000
`define CAL_RESET         14'h0000

// Conversion and calibration run lengths in cycles
`define CONV_CYCLES       8'h12
`define CAL_CYCLES        8'h40

`endif

// file: hw/cal_pointer.v
// Calibration register pointer sequencer
`timescale 1ns/1ps
`default_nettype none
`include "conv_regs_defs.vh"

module cal_pointer (
    // Clock and reset
    input  wire       core_clk_i,
    input  wire       srst_i,
    // Control
    input  wire       load_i,
    input  wire [1:0] group_i,
    input  wire       step_i,
    // Pointer
    output reg  [3:0] ptr_o
);

    function [3:0] first_slot;
        input [1:0] grp;
        begin
            first_slot = (grp == `GRP_OFS) ? `PTR_OFS : `PTR_GAIN;
        end
    endfunction

    function [3:0] last_slot;
        input [1:0] grp;
        begin
            if (grp == `GRP_ALL) begin
                last_slot = `PTR_DAC_LAST;
            end else if (grp == `GRP_GAIN_OFS) begin
                last_slot = `PTR_OFS;
            end else begin
                last_slot = first_slot(grp);
            end
        end
    endfunction

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            ptr_o <= `PTR_GAIN;
        end else if (load_i) begin
            ptr_o <= first_slot(group_i);
        end else if (step_i) begin
            if (ptr_o == last_slot(group_i)) begin
                ptr_o <= first_slot(group_i);
            end else begin
                ptr_o <= ptr_o + 4'h1;
            end
        end
    end

endmodule
`default_nettype wire

// file: hw/conv_status_cal.v
// Converter status word and calibration register access
// What this block does
// - Status word is 16 bits, read only; writes to its address never change it.
// - Status word reads 00C0 after reset; only bits 7..6 are set.
// - Status bit 15 always reads zero.
// - Bit 14 is one while converting or calibrating.
// - Bits 13..10 give single/differential flag and channel bits.
// - Bits 9..8 give the power setting bits.
// - Bits 7 and 6 always read one.
// - Bit 5 shows interface mode; mode bit clears after each read.
// - Bit 3 shows calibration kind: zero self, one system.
// - Bit 0 is one while a calibration runs.
// - Bits 2..1 give the calibration group select.
// - Ten calibration registers: gain, offset, eight DAC.
// - Group select 00 all, 01 gain+offset, 10 offset, 11 gain.
// - Pointer resets on control write and after the last access.
// - Pointer starts at gain, except offset-only starts at offset.
// - Pointer advances after each access made while idle in multi-register groups.
// - An abandoned sequence is reset by the next control write.
// - Calibration reads return two leading zero bits.
// - Start-calibration bit clears when calibration ends.
// - Without start bit, group select only addresses registers.
// - Offset and gain registers: two zeros then 14 data bits.
`timescale 1ns/1ps
`default_nettype none
`include "conv_regs_defs.vh"

module conv_status_cal #(
    parameter [7:0] CONV_LEN = `CONV_CYCLES,
    parameter [7:0] CAL_LEN  = `CAL_CYCLES
) (
    // Clock and reset
    input  wire        core_clk_i,
    input  wire        srst_i,
    // Register port
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    // Converter state
    input  wire        sleep_n_i,
    output wire        busy_o,
    output wire        cal_running_o,
    output wire        powered_down_o
);

    localparam [7:0] CONV_N = CONV_LEN;
    localparam [7:0] CAL_N  = CAL_LEN;

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_CAL  = 3'b100;

    // Control fields
    reg        sgl_q;
    reg [2:0]  chan_q;
    reg [1:0]  pwr_q;
    reg [1:0]  rd_target_q;
    reg        mode_q;
    reg        kind_q;
    reg [1:0]  group_q;
    reg        start_q;
    reg [2:0]  state_q;
    reg [7:0]  count_q;
    reg [13:0] cal_mem_q [0:`CAL_COUNT-1];

    wire [3:0] ptr;
    wire       ctl_wr   = wr_i && (addr_i == `ADDR_CONTROL);
    wire       data_wr  = wr_i && (addr_i == `ADDR_DATA);
    wire       data_rd  = rd_i && (addr_i == `ADDR_DATA);
    wire       cal_rd   = data_rd && (rd_target_q == `RD_CAL);
    wire       idle     = (state_q == ST_IDLE);
    // Coefficients are only touched while nothing runs, avoiding a clash with the sequencer
    wire       cal_step = idle && (data_wr || cal_rd);

    cal_pointer u_ptr (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .load_i     (ctl_wr),
        .group_i    (ctl_wr ? wdata_i[`CTL_GRP_HI:`CTL_GRP_LO] : group_q),
        .step_i     (cal_step),
        .ptr_o      (ptr)
    );

    assign busy_o         = !idle;
    assign cal_running_o  = (state_q == ST_CAL);
    assign powered_down_o = !sleep_n_i && (pwr_q != 2'h0);

    wire [15:0] status_word = {1'b0,
                               busy_o,
                               sgl_q, chan_q,
                               pwr_q,
                               2'b11,
                               mode_q,
                               1'b0,
                               kind_q,
                               group_q,
                               start_q};

    integer i;

    // Control word and run sequencer
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            sgl_q       <= 1'b0;
            chan_q      <= 3'h0;
            pwr_q       <= 2'h0;
            rd_target_q <= 2'h0;
            mode_q      <= 1'b0;
            kind_q      <= 1'b0;
            group_q     <= 2'h0;
            start_q     <= 1'b0;
            state_q     <= ST_IDLE;
            count_q     <= 8'h00;
        end else begin
            if (rd_i) begin
                mode_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (ctl_wr) begin
                        if (wdata_i[`CTL_START_BIT]) begin
                            state_q <= ST_CAL;
                            count_q <= CAL_N;
                        end else if (wdata_i[`CTL_CONV_BIT]) begin
                            state_q <= ST_CONV;
                            count_q <= CONV_N;
                        end
                    end
                end
                ST_CONV: begin
                    if (count_q == 8'h01) begin
                        state_q <= ST_IDLE;
                    end
                    count_q <= count_q - 8'h01;
                end
                ST_CAL: begin
                    if (count_q == 8'h01) begin
                        state_q <= ST_IDLE;
                        start_q <= 1'b0;
                    end
                    count_q <= count_q - 8'h01;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            if (ctl_wr) begin
                sgl_q       <= wdata_i[`CTL_SGL_BIT];
                chan_q      <= wdata_i[`CTL_CH_HI:`CTL_CH_LO];
                pwr_q       <= wdata_i[`CTL_PWR_HI:`CTL_PWR_LO];
                rd_target_q <= wdata_i[`CTL_RD_HI:`CTL_RD_LO];
                mode_q      <= wdata_i[`CTL_MODE_BIT];
                kind_q      <= wdata_i[`CTL_KIND_BIT];
                group_q     <= wdata_i[`CTL_GRP_HI:`CTL_GRP_LO];
                // A start write during a run is ignored so the flag tracks the run
                if (idle) begin
                    start_q <= wdata_i[`CTL_START_BIT];
                end
            end
        end
    end

    // Calibration coefficients
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            for (i = 0; i < `CAL_COUNT; i = i + 1) begin
                cal_mem_q[i] <= `CAL_RESET;
            end
        end else if (data_wr && idle) begin
            cal_mem_q[ptr] <= wdata_i[13:0];
        end
    end

    // Read data, one cycle after the strobe
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            if (addr_i == `ADDR_STATUS) begin
                rdata_o <= status_word;
            end else if (addr_i == `ADDR_CONTROL) begin
                rdata_o <= {rd_target_q, 12'h000, busy_o, cal_running_o};
            end else if (data_rd && rd_target_q == `RD_STATUS) begin
                rdata_o <= status_word;
            end else if (cal_rd) begin
                rdata_o <= {2'b00, cal_mem_q[ptr]};
            end else begin
                rdata_o <= 16'h0000;
            end
        end else begin
            rdata_o <= 16'h0000;
        end
    end

endmodule
`default_nettype wire

// file: tb/conv_status_cal_asserts.sv
// Concurrent checks on the status and calibration register port
`timescale 1ns/1ps
`default_nettype none
`include "conv_regs_defs.vh"
module conv_status_cal_asserts #(
    parameter CONV_LEN = 18,
    parameter CAL_LEN  = 64
) (
    input wire logic        core_clk_i,
    input wire logic        srst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        sleep_n_i,
    input wire logic        busy_o,
    input wire logic        cal_running_o,
    input wire logic        powered_down_o
);
    localparam int CAL_MAX = CAL_LEN + 2;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    sequence s_stat_rd; rd_i && addr_i == `ADDR_STATUS; endsequence
    // Read target of the last control write, so data reads of the status word are excluded
    logic [1:0] target_q;
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            target_q <= 2'h0;
        end else if (wr_i && addr_i == `ADDR_CONTROL) begin
            target_q <= wdata_i[`CTL_RD_HI:`CTL_RD_LO];
        end
    end
    sequence s_cal_rd; rd_i && addr_i == `ADDR_DATA && target_q == `RD_CAL; endsequence
    AST_IDLE_ZERO: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero without a read");
    AST_TOP_ZERO: assert property (s_stat_rd |=> !rdata_o[15])
        else $error("status bit 15 set");
    AST_TAG_ONES: assert property (s_stat_rd |=> rdata_o[7:6] == 2'b11)
        else $error("status bits 7..6 not ones");
    AST_BUSY_BIT: assert property (s_stat_rd |=> rdata_o[14] == $past(busy_o))
        else $error("status busy bit wrong");
    AST_CAL_BIT: assert property (s_stat_rd |=> rdata_o[0] == $past(cal_running_o))
        else $error("status calibration bit wrong");
    AST_CAL_LEAD: assert property (s_cal_rd |=> rdata_o[15:14] == 2'b00)
        else $error("coefficient leading bits not zero");
    AST_CAL_END: assert property ($rose(cal_running_o) |-> ##[1:CAL_MAX] !cal_running_o)
        else $error("calibration never ends");
    AST_CAL_IN_BUSY: assert property (cal_running_o |-> busy_o)
        else $error("calibration running without busy");
    AST_PWR_SLEEP: assert property (powered_down_o |-> !sleep_n_i)
        else $error("powered down while sleep pin high");
endmodule
`default_nettype wire

// file: tb/host_model.sv
// Host side master for the converter register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic        core_clk_i,
    // Register port
    output logic [3:0]       addr_o,
    output logic [15:0]      wdata_o,
    output logic             wr_o,
    output logic             rd_o,
    input  wire logic [15:0] rdata_i
);
    initial begin
        addr_o = 4'hf;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge core_clk_i);
        wr_o    <= 1'b0;
        // Released lines must not keep the last value
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge core_clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1 d = rdata_i;
    endtask
endmodule
`default_nettype wire

// file: tb/test_conv_status_cal.sv
// Self-checking bench for the status and calibration register block
`timescale 1ns/1ps
`default_nettype none
`include "conv_regs_defs.vh"
`define CHK(n, e, a) check(n, e, a)
module test_conv_status_cal;
    logic        core_clk_i = 0;
    logic        srst_i = 1;
    logic        sleep_n_i = 1;
    wire [3:0]   addr_i;
    wire [15:0]  wdata_i, rdata_o;
    wire         wr_i, rd_i, busy_o, cal_running_o, powered_down_o;
    logic [15:0] d;
    logic [13:0] coef [10];
    int          n_fail = 0;
    int          tests_run = 0;
    always #25 core_clk_i = ~core_clk_i;
    conv_status_cal #(.CONV_LEN(3), .CAL_LEN(8)) u_conv_status_cal (.core_clk_i, .srst_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_n_i, .busy_o, .cal_running_o, .powered_down_o);
    host_model u_host_model (.core_clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i),
        .rdata_i(rdata_o));
    task automatic check(string n, logic [15:0] e, logic [15:0] a);
        tests_run++;
        if (a !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, a);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic ctl(logic [15:0] w);
        u_host_model.wr(`ADDR_CONTROL, w);
        #1;
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 60 && busy_o !== 1'b0; i++) @(posedge core_clk_i);
        #1;
        if (busy_o !== 1'b0) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic t_status;
        ctl(16'h3bea);
        u_host_model.rd(`ADDR_DATA, d);
        `CHK("status fields", 16'h3bea, d);
        u_host_model.rd(`ADDR_STATUS, d);
        `CHK("mode cleared", 16'h3bca, d);
        u_host_model.wr(`ADDR_STATUS, 16'hffff);
        u_host_model.rd(`ADDR_STATUS, d);
        `CHK("status read only", 16'h3bca, d);
        @(posedge core_clk_i) sleep_n_i <= 1'b0;
        #1 `CHK("powered down", 1'b1, powered_down_o);
        @(posedge core_clk_i) sleep_n_i <= 1'b1;
        #1 `CHK("powered up", 1'b0, powered_down_o);
        $display("test status done");
    endtask
    task automatic t_run;
        ctl(16'h00c1);
        `CHK("cal busy", 2'b11, {busy_o, cal_running_o});
        u_host_model.rd(`ADDR_STATUS, d);
        `CHK("status during cal", 16'h40c1, d);
        u_host_model.rd(`ADDR_CONTROL, d);
        `CHK("control readback", 16'hc003, d);
        wait_idle();
        u_host_model.rd(`ADDR_STATUS, d);
        `CHK("status after cal", 16'h00c0, d);
        ctl(16'h00d0);
        `CHK("conv busy", 2'b10, {busy_o, cal_running_o});
        wait_idle();
        $display("test run done");
    endtask
    task automatic t_coef;
        ctl(16'h0000);
        `CHK("no start", 1'b0, busy_o);
        for (int i = 0; i < 10; i++) begin
            coef[i] = 14'h1a50 + 14'(i);
            u_host_model.wr(`ADDR_DATA, {2'b11, coef[i]});
        end
        ctl(16'h0080);
        for (int i = 0; i < 11; i++) begin
            u_host_model.rd(`ADDR_DATA, d);
            `CHK("full walk", {2'b00, coef[i % 10]}, d);
        end
        for (int g = 1; g < 4; g++) begin
            ctl(16'h0080 | 16'(g << 1));
            for (int k = 0; k < 3; k++) begin
                u_host_model.rd(`ADDR_DATA, d);
                `CHK("group walk", {2'b00, coef[g == 1 ? k % 2 : (g == 2 ? 1 : 0)]}, d);
            end
        end
        ctl(16'h0080);
        repeat (3) u_host_model.rd(`ADDR_DATA, d);
        ctl(16'h0080);
        u_host_model.rd(`ADDR_DATA, d);
        `CHK("abort reset", {2'b00, coef[0]}, d);
        $display("test coefficients done");
    endtask
    initial begin
        repeat (16) @(posedge core_clk_i);
        srst_i <= 1'b0;
        #1 `CHK("reset state", 16'h0000, rdata_o);
        `CHK("reset busy", 16'h0000, {15'h0000, busy_o});
        u_host_model.rd(`ADDR_STATUS, d);
        `CHK("power-up status", 16'h00c0, d);
        t_status();
        t_run();
        t_coef();
        tally_and_finish();
    end
endmodule
bind conv_status_cal conv_status_cal_asserts #(.CONV_LEN(CONV_LEN), .CAL_LEN(CAL_LEN)) u_asserts (.core_clk_i,
    .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_n_i, .busy_o, .cal_running_o, .powered_down_o);
`default_nettype wire
